// File: hw/ifec_defs.svh
`ifndef IFEC_DEFS_SVH
`define IFEC_DEFS_SVH

// register indices on the plain register port
`define IFEC_OFS_CTL1      4'h0
`define IFEC_OFS_CTL2      4'h1
`define IFEC_OFS_FLAGS0    4'h2
`define IFEC_OFS_FLAGS1    4'h3
`define IFEC_OFS_FLAGS4    4'h4
`define IFEC_OFS_ENABLE0   4'h5
`define IFEC_OFS_ENABLE1   4'h6

// control register one fields
`define IFEC_BIT_NEST_DIS  15
`define IFEC_BIT_DIV0      6
`define IFEC_BIT_ARITH     4
`define IFEC_BIT_ADDR      3
`define IFEC_BIT_STACK     2
`define IFEC_BIT_OSC       1

// control register two fields
`define IFEC_BIT_ALT_TBL   15
`define IFEC_BIT_TIMED_DIS 14
`define IFEC_BIT_EXT0_POL  0
`define IFEC_BIT_EXT1_POL  1
`define IFEC_BIT_EXT2_POL  2

// positions of the external request flags
`define IFEC_BIT_EXT0_FLAG 0
`define IFEC_BIT_EXT1_FLAG 4
`define IFEC_BIT_EXT2_FLAG 13

// implemented-bit masks
`define IFEC_MASK_CTL1     16'h805e
`define IFEC_MASK_CTL2_WR  16'h8007
`define IFEC_MASK_FLAGS0   16'h3fef
`define IFEC_MASK_FLAGS1   16'h20db
`define IFEC_MASK_FLAGS4   16'h0002

// reset values
`define IFEC_RST_REG       16'h0000
`define IFEC_RST_POL       3'h0

// clocks after reset before the pin edge history holds real samples
`define IFEC_EXT_WARM      2'h3

`endif

// File: hw/ifec_pkg.sv
package ifec_pkg;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} ifec_bus_t;

	typedef struct packed {
		logic arith;
		logic div0_cause;
		logic addr;
		logic stack;
		logic osc;
	} ifec_trap_t;

	typedef struct packed {
		logic [15:0] flags0;
		logic [15:0] flags1;
		logic [15:0] flags4;
	} ifec_evt_t;

endpackage

// File: hw/ifec_top.sv
`include "ifec_defs.svh"

// How it works
// - nesting disable bit blocks preemption of service
// - divide-by-zero bit records cause of arith trap
// - arith trap status bit sticks once trapped
// - address trap status bit sticks once trapped
// - stack trap status bit sticks once trapped
// - oscillator failure status bit sticks once trapped
// - unimplemented bits ignore writes, read zero
// - alternate table select picks vector table
// - timed disable status read-only, shows core state
// - polarity one falling edge, zero rising edge
// - flag register zero bit layout
// - request flags read/write, reset to zero
// - flag register one bit layout
// - flag register four holds serial error only
// - enable zero mirrors flag zero positions
// - enable one mirrors flag one positions
// - enable bits read/write, reset to zero
// - sources set flags, software writes clear
// - priority level read-only while nesting disabled
module ifec_top #(
	parameter int EXT_PINS = 3
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire ifec_pkg::ifec_bus_t bus_req,
	output logic [15:0]              rd_data,
	input  wire ifec_pkg::ifec_trap_t trap_evt,
	input  wire ifec_pkg::ifec_evt_t  src_evt,
	input  wire logic [EXT_PINS-1:0] ext_pin,
	input  wire logic                timed_disable_active,
	input  wire logic                in_service,
	input  wire logic                new_higher_level,
	output logic                     preempt_allow,
	input  wire logic                cpu_priority_level_wr_req,
	output logic                     cpu_priority_level_wr_en,
	output logic                     alt_table_select,
	output logic [15:0]              pend0,
	output logic [15:0]              pend1,
	output logic [15:0]              serial_error_req
);

	// one shared decode keeps every write port in step
	function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
		hit = (a == idx);
	endfunction

	logic [15:0] wr_val;
	logic        wr_ctl1;
	logic        wr_ctl2;
	logic        wr_f0;
	logic        wr_f1;
	logic        wr_f4;
	logic        wr_e0;
	logic        wr_e1;

	assign wr_val  = bus_req.wdata;
	assign wr_ctl1 = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_CTL1);
	assign wr_ctl2 = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_CTL2);
	assign wr_f0   = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_FLAGS0);
	assign wr_f1   = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_FLAGS1);
	assign wr_f4   = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_FLAGS4);
	assign wr_e0   = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_ENABLE0);
	assign wr_e1   = bus_req.wr & hit(bus_req.addr, `IFEC_OFS_ENABLE1);

	// control register one

	logic nesting_disable_r;
	logic divide_by_zero_status_r;
	logic arith_trap_status_r;
	logic address_trap_status_r;
	logic stack_trap_status_r;
	logic osc_failure_trap_status_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			nesting_disable_r <= 1'b0;
		end else if (wr_ctl1) begin
			nesting_disable_r <= wr_val[`IFEC_BIT_NEST_DIS];
		end
	end

	// a trap in the same cycle as a software write wins over the write
	always_ff @(posedge clk) begin
		if (rst) begin
			divide_by_zero_status_r <= 1'b0;
		end else if (trap_evt.arith) begin
			divide_by_zero_status_r <= trap_evt.div0_cause;
		end else if (wr_ctl1) begin
			divide_by_zero_status_r <= wr_val[`IFEC_BIT_DIV0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			arith_trap_status_r <= 1'b0;
		end else if (trap_evt.arith) begin
			arith_trap_status_r <= 1'b1;
		end else if (wr_ctl1) begin
			arith_trap_status_r <= wr_val[`IFEC_BIT_ARITH];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			address_trap_status_r <= 1'b0;
		end else if (trap_evt.addr) begin
			address_trap_status_r <= 1'b1;
		end else if (wr_ctl1) begin
			address_trap_status_r <= wr_val[`IFEC_BIT_ADDR];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stack_trap_status_r <= 1'b0;
		end else if (trap_evt.stack) begin
			stack_trap_status_r <= 1'b1;
		end else if (wr_ctl1) begin
			stack_trap_status_r <= wr_val[`IFEC_BIT_STACK];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_failure_trap_status_r <= 1'b0;
		end else if (trap_evt.osc) begin
			osc_failure_trap_status_r <= 1'b1;
		end else if (wr_ctl1) begin
			osc_failure_trap_status_r <= wr_val[`IFEC_BIT_OSC];
		end
	end

	logic [15:0] ctl1_view;

	always_comb begin
		ctl1_view                     = `IFEC_RST_REG;
		ctl1_view[`IFEC_BIT_NEST_DIS] = nesting_disable_r;
		ctl1_view[`IFEC_BIT_DIV0]     = divide_by_zero_status_r;
		ctl1_view[`IFEC_BIT_ARITH]    = arith_trap_status_r;
		ctl1_view[`IFEC_BIT_ADDR]     = address_trap_status_r;
		ctl1_view[`IFEC_BIT_STACK]    = stack_trap_status_r;
		ctl1_view[`IFEC_BIT_OSC]      = osc_failure_trap_status_r;
	end

	// control register two

	logic                alt_table_select_r;
	logic [EXT_PINS-1:0] ext_polarity_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			alt_table_select_r <= 1'b0;
		end else if (wr_ctl2) begin
			alt_table_select_r <= wr_val[`IFEC_BIT_ALT_TBL];
		end
	end

	// the timed disable bit is never stored here, so writes cannot touch it
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_polarity_r <= `IFEC_RST_POL;
		end else if (wr_ctl2) begin
			ext_polarity_r <= wr_val[EXT_PINS-1:0];
		end
	end

	logic [15:0] ctl2_view;

	always_comb begin
		ctl2_view                      = `IFEC_RST_REG;
		ctl2_view[`IFEC_BIT_ALT_TBL]   = alt_table_select_r;
		ctl2_view[`IFEC_BIT_TIMED_DIS] = timed_disable_active;
		ctl2_view[EXT_PINS-1:0]        = ext_polarity_r;
	end

	// external pins: synchronise, then edge detect per polarity

	logic [1:0]          ext_warm_r;
	logic [EXT_PINS-1:0] ext_meta_r;
	logic [EXT_PINS-1:0] ext_sync_r;
	logic [EXT_PINS-1:0] ext_prev_r;
	logic [EXT_PINS-1:0] ext_edge;

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_meta_r <= '0;
			ext_sync_r <= '0;
			ext_prev_r <= '0;
		end else begin
			ext_meta_r <= ext_pin;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	// no edge counts until the history holds real pin samples; a pin that sits
	// high through reset would otherwise look like a rising edge
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_warm_r <= 2'h0;
		end else if (ext_warm_r != `IFEC_EXT_WARM) begin
			ext_warm_r <= ext_warm_r + 2'h1;
		end
	end

	// the edge history ignores polarity, so changing it never fakes an edge
	genvar gi;
	generate
		for (gi = 0; gi < EXT_PINS; gi++) begin : g_edge
			assign ext_edge[gi] = (ext_warm_r == `IFEC_EXT_WARM) &
			                      (ext_polarity_r[gi] ? (ext_prev_r[gi] & ~ext_sync_r[gi])
			                                          : (~ext_prev_r[gi] & ext_sync_r[gi]));
		end
	endgenerate

	logic [15:0] set0;
	logic [15:0] set1;
	logic [15:0] set4;

	always_comb begin
		set0                      = src_evt.flags0;
		set0[`IFEC_BIT_EXT0_FLAG] = src_evt.flags0[`IFEC_BIT_EXT0_FLAG] | ext_edge[0];
		set1                      = src_evt.flags1;
		set1[`IFEC_BIT_EXT1_FLAG] = src_evt.flags1[`IFEC_BIT_EXT1_FLAG] | ext_edge[1];
		set1[`IFEC_BIT_EXT2_FLAG] = src_evt.flags1[`IFEC_BIT_EXT2_FLAG] | ext_edge[2];
		set4                      = src_evt.flags4;
	end

	// request flags

	logic [15:0] flags0_r;
	logic [15:0] flags1_r;
	logic [15:0] flags4_r;
	logic [15:0] flags0_nxt;
	logic [15:0] flags1_nxt;
	logic [15:0] flags4_nxt;

	// hardware sets OR in after the write so a set never gets lost
	assign flags0_nxt = ((wr_f0 ? wr_val : flags0_r) | set0) & `IFEC_MASK_FLAGS0;
	assign flags1_nxt = ((wr_f1 ? wr_val : flags1_r) | set1) & `IFEC_MASK_FLAGS1;
	assign flags4_nxt = ((wr_f4 ? wr_val : flags4_r) | set4) & `IFEC_MASK_FLAGS4;

	always_ff @(posedge clk) begin
		if (rst) begin
			flags0_r <= `IFEC_RST_REG;
		end else begin
			flags0_r <= flags0_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags1_r <= `IFEC_RST_REG;
		end else begin
			flags1_r <= flags1_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags4_r <= `IFEC_RST_REG;
		end else begin
			flags4_r <= flags4_nxt;
		end
	end

	// enables

	logic [15:0] enable0_r;
	logic [15:0] enable1_r;
	logic [15:0] enable0_nxt;
	logic [15:0] enable1_nxt;

	// pending uses the enable as written on the same edge, so a cleared enable leaves no stale request
	assign enable0_nxt = wr_e0 ? (wr_val & `IFEC_MASK_FLAGS0) : enable0_r;
	assign enable1_nxt = wr_e1 ? (wr_val & `IFEC_MASK_FLAGS1) : enable1_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			enable0_r <= `IFEC_RST_REG;
		end else if (wr_e0) begin
			enable0_r <= wr_val & `IFEC_MASK_FLAGS0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enable1_r <= `IFEC_RST_REG;
		end else if (wr_e1) begin
			enable1_r <= wr_val & `IFEC_MASK_FLAGS1;
		end
	end

	// outputs towards arbitration and the core

	always_ff @(posedge clk) begin
		if (rst) begin
			pend0            <= `IFEC_RST_REG;
			pend1            <= `IFEC_RST_REG;
			serial_error_req <= `IFEC_RST_REG;
		end else begin
			pend0            <= flags0_nxt & enable0_nxt;
			pend1            <= flags1_nxt & enable1_nxt;
			serial_error_req <= flags4_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alt_table_select <= 1'b0;
		end else begin
			alt_table_select <= (wr_ctl2) ? wr_val[`IFEC_BIT_ALT_TBL] : alt_table_select_r;
		end
	end

	// combinational so the core sees the decision in the cycle it asks
	assign preempt_allow            = ~in_service | (~nesting_disable_r & new_higher_level);
	assign cpu_priority_level_wr_en = cpu_priority_level_wr_req & ~nesting_disable_r;

	// read port: data stands one cycle after the strobe, else zero

	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = `IFEC_RST_REG;
		if (hit(bus_req.addr, `IFEC_OFS_CTL1)) begin
			rd_mux = ctl1_view;
		end else if (hit(bus_req.addr, `IFEC_OFS_CTL2)) begin
			rd_mux = ctl2_view;
		end else if (hit(bus_req.addr, `IFEC_OFS_FLAGS0)) begin
			rd_mux = flags0_r;
		end else if (hit(bus_req.addr, `IFEC_OFS_FLAGS1)) begin
			rd_mux = flags1_r;
		end else if (hit(bus_req.addr, `IFEC_OFS_FLAGS4)) begin
			rd_mux = flags4_r;
		end else if (hit(bus_req.addr, `IFEC_OFS_ENABLE0)) begin
			rd_mux = enable0_r;
		end else if (hit(bus_req.addr, `IFEC_OFS_ENABLE1)) begin
			rd_mux = enable1_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data <= `IFEC_RST_REG;
		end else if (bus_req.rd) begin
			rd_data <= rd_mux;
		end else begin
			rd_data <= `IFEC_RST_REG;
		end
	end

endmodule // ifec_top

// File: sim/ifec_core_model.sv
module ifec_core_model (
	input  wire logic            clk,
	output ifec_pkg::ifec_trap_t trap_evt,
	output ifec_pkg::ifec_evt_t  src_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		trap_evt = '0;
		src_evt = '0;
	end
	// delay lets a source answer promptly or late; pulses are one cycle as the core gives them
	task automatic fire(input ifec_pkg::ifec_trap_t t, input ifec_pkg::ifec_evt_t e, input int dly);
		repeat (dly) @(posedge clk);
		trap_evt <= t;
		src_evt <= e;
		@(posedge clk);
		trap_evt <= '0;
		src_evt <= '0;
	endtask
endmodule // ifec_core_model

// File: sim/ifec_top_assertions.sv
`include "ifec_defs.svh"
module ifec_top_assertions (
	input wire logic                clk,
	input wire logic                rst,
	input wire ifec_pkg::ifec_bus_t bus_req,
	input wire logic [15:0]         rd_data,
	input wire ifec_pkg::ifec_evt_t src_evt,
	input wire logic                timed_disable_active,
	input wire logic                in_service,
	input wire logic                cpu_priority_level_wr_req,
	input wire logic                cpu_priority_level_wr_en,
	input wire logic                preempt_allow,
	input wire logic                alt_table_select,
	input wire logic [15:0]         pend0,
	input wire logic [15:0]         serial_error_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic nest_r;
	// shadow of the nesting bit, kept from bus writes only
	always_ff @(posedge clk) begin
		if (rst)
			nest_r <= 1'b0;
		else if (bus_req.wr && bus_req.addr == `IFEC_OFS_CTL1)
			nest_r <= bus_req.wdata[15];
	end
	property p_nest; in_service && nest_r |-> !preempt_allow; endproperty
	a_nest: assert property (p_nest) else $error("preempt while nesting off");
	property p_level_gate; cpu_priority_level_wr_req |-> cpu_priority_level_wr_en == !nest_r; endproperty
	a_level_gate: assert property (p_level_gate) else $error("level write gate wrong");
	property p_unmap; bus_req.rd && bus_req.addr > 4'h6 |=> rd_data == 16'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_ctl1; bus_req.rd && bus_req.addr == `IFEC_OFS_CTL1 |=> (rd_data & ~`IFEC_MASK_CTL1) == 16'h0; endproperty
	a_ctl1: assert property (p_ctl1) else $error("ctl1 spare bit set");
	property p_f4; bus_req.rd && bus_req.addr == `IFEC_OFS_FLAGS4 |=> (rd_data & 16'hfffd) == 16'h0; endproperty
	a_f4: assert property (p_f4) else $error("flags4 spare bit set");
	property p_alt; bus_req.wr && bus_req.addr == `IFEC_OFS_CTL2 |=> alt_table_select == $past(bus_req.wdata[15]); endproperty
	a_alt: assert property (p_alt) else $error("table select wrong");
	property p_timed; bus_req.rd && bus_req.addr == `IFEC_OFS_CTL2 |=> rd_data[14] == $past(timed_disable_active); endproperty
	a_timed: assert property (p_timed) else $error("timed disable bit wrong");
	property p_off; bus_req.wr && bus_req.addr == `IFEC_OFS_ENABLE0 && bus_req.wdata == 16'h0 |=> pend0 == 16'h0; endproperty
	a_off: assert property (p_off) else $error("pending without enable");
	property p_set; src_evt.flags4[1] |=> serial_error_req[1]; endproperty
	a_set: assert property (p_set) else $error("serial error not set");
endmodule // ifec_top_assertions
bind ifec_top ifec_top_assertions u_chk (.clk, .rst, .bus_req, .rd_data, .src_evt, .timed_disable_active,
	.in_service, .cpu_priority_level_wr_req, .cpu_priority_level_wr_en, .preempt_allow, .alt_table_select,
	.pend0, .serial_error_req);

// File: sim/irq_flag_enable_control_bench.sv
`include "ifec_defs.svh"
module irq_flag_enable_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	ifec_pkg::ifec_bus_t  bus_req = '0;
	ifec_pkg::ifec_trap_t trap_evt;
	ifec_pkg::ifec_evt_t  src_evt;
	logic [2:0]           ext_pin = 3'h0;
	logic                 timed_disable_active = 1'b0;
	logic                 in_service = 1'b0;
	logic                 new_higher_level = 1'b0;
	logic                 cpu_priority_level_wr_req = 1'b0;
	logic                 preempt_allow, cpu_priority_level_wr_en, alt_table_select;
	logic [15:0]          rd_data, pend0, pend1, serial_error_req;
	int                   bad_count = 0;
	int                   checked = 0;
	int                   cyc = 0;
	always #50 clk = ~clk;
	ifec_top dut (.clk, .rst, .bus_req, .rd_data, .trap_evt, .src_evt, .ext_pin, .timed_disable_active, .in_service,
		.new_higher_level, .preempt_allow, .cpu_priority_level_wr_req, .cpu_priority_level_wr_en,
		.alt_table_select, .pend0, .pend1, .serial_error_req);
	ifec_core_model src (.clk, .trap_evt, .src_evt);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		chk(rd_data, exp);
	endtask
	task automatic t_masks;
		logic [15:0] m [8] = '{16'h805e, 16'h8007, 16'h3fef, 16'h20db, 16'h0002, 16'h3fef, 16'h20db, 16'h0};
		for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0);
		for (int a = 0; a < 8; a++) wr(a[3:0], 16'hffff);
		for (int a = 0; a < 8; a++) rd(a[3:0], m[a]);
		chk(pend0, 16'h3fef);
		chk(pend1, 16'h20db);
		chk({15'h0, alt_table_select}, 16'h1);
		@(posedge clk);
		in_service <= 1'b1;
		new_higher_level <= 1'b1;
		cpu_priority_level_wr_req <= 1'b1;
		@(negedge clk);
		chk({14'h0, preempt_allow, cpu_priority_level_wr_en}, 16'h0);
		wr(`IFEC_OFS_CTL1, 16'h0);
		@(negedge clk);
		chk({14'h0, preempt_allow, cpu_priority_level_wr_en}, 16'h3);
		for (int a = 0; a < 7; a++) wr(a[3:0], 16'h0);
	endtask
	task automatic t_traps;
		src.fire('1, '{flags0: 16'h2000, flags1: 16'h0080, flags4: 16'h0002}, 3);
		rd(`IFEC_OFS_CTL1, 16'h005e);
		rd(`IFEC_OFS_FLAGS0, 16'h2000);
		rd(`IFEC_OFS_FLAGS1, 16'h0080);
		chk(pend0, 16'h0);
		chk(serial_error_req, 16'h0002);
		wr(`IFEC_OFS_ENABLE0, 16'h2000);
		@(negedge clk);
		chk(pend0, 16'h2000);
		wr(`IFEC_OFS_ENABLE0, 16'h0);
		@(negedge clk);
		chk(pend0, 16'h0);
		rd(`IFEC_OFS_FLAGS0, 16'h2000);
		src.fire('{arith: 1'b1, default: 1'b0}, '0, 1);
		rd(`IFEC_OFS_CTL1, 16'h001e);
		for (int a = 0; a < 7; a++) wr(a[3:0], 16'h0);
		rd(`IFEC_OFS_FLAGS0, 16'h0);
	endtask
	task automatic t_ext;
		wr(`IFEC_OFS_CTL2, 16'h0002);
		@(posedge clk);
		ext_pin <= 3'h3;
		timed_disable_active <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`IFEC_OFS_FLAGS0, 16'h0001);
		rd(`IFEC_OFS_FLAGS1, 16'h0000);
		@(posedge clk);
		ext_pin <= 3'h4;
		repeat (4) @(posedge clk);
		rd(`IFEC_OFS_FLAGS1, 16'h2010);
		wr(`IFEC_OFS_CTL2, 16'hbfff);
		rd(`IFEC_OFS_CTL2, 16'hc007);
	endtask
	// reset in mid-run with ext2 held high: registers clear and no false edge follows
	task automatic t_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`IFEC_OFS_FLAGS0, 16'h0);
		rd(`IFEC_OFS_FLAGS1, 16'h0);
		rd(`IFEC_OFS_CTL2, 16'h4000);
		chk({15'h0, alt_table_select}, 16'h0);
	endtask
	task automatic print_verdict;
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ceiling well above the roughly 150 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_masks;
		t_traps;
		t_ext;
		t_reset;
		print_verdict;
	end
endmodule // irq_flag_enable_control_bench
